// ===== shared/wgt_pkg.sv
package wgt_pkg;

  localparam int DW = 8;
  localparam int AW = 8;
  localparam int RW = 17;
  localparam int EV_W = 4;

  // register bus request from the host interface logic
  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic          wr;
    logic          rd;
  } wgt_bus_req_t;

  // register offsets
  localparam logic [AW-1:0] ADDR_SLEEP_CTRL  = 8'h2d;
  localparam logic [AW-1:0] ADDR_WAKE_DIV    = 8'h2e;
  localparam logic [AW-1:0] ADDR_WAKE_INT_HI = 8'h2f;
  localparam logic [AW-1:0] ADDR_WAKE_INT_LO = 8'h30;
  localparam logic [AW-1:0] ADDR_POST_DUR    = 8'h31;
  localparam logic [AW-1:0] ADDR_GT_CTRL     = 8'h32;
  localparam logic [AW-1:0] ADDR_GT_DIV      = 8'h33;
  localparam logic [AW-1:0] ADDR_GT1_PER     = 8'h34;
  localparam logic [AW-1:0] ADDR_GT2_PER     = 8'h35;
  localparam logic [AW-1:0] ADDR_IRQ_STAT    = 8'h50;
  localparam logic [AW-1:0] ADDR_IRQ_MASK    = 8'h51;
  localparam logic [AW-1:0] ADDR_GT1_CNT     = 8'h52;
  localparam logic [AW-1:0] ADDR_GT2_CNT     = 8'h53;

  // field positions
  localparam int SC_SRC_BIT     = 2;
  localparam int SC_WAKE_EN_BIT = 4;
  localparam int SC_POST_EN_BIT = 5;
  localparam int GT1_RUN_BIT    = 0;
  localparam int GT1_SRC_BIT    = 1;
  localparam int GT2_RUN_BIT    = 4;
  localparam int GT2_SRC_BIT    = 5;
  localparam int DIV_LO_LSB     = 0;
  localparam int DIV_HI_LSB     = 4;
  localparam int EV_GT1         = 0;
  localparam int EV_GT2         = 1;
  localparam int EV_WAKE        = 2;
  localparam int EV_POST        = 3;

  // reset values and writable masks
  localparam logic [DW-1:0]   SLEEP_CTRL_RST = 8'h04;
  localparam logic [DW-1:0]   SLEEP_CTRL_MSK = 8'h34;
  localparam logic [DW-1:0]   REG_RST        = 8'h00;
  localparam logic [EV_W-1:0] EV_RST         = 4'h0;

  // prescale ratios
  localparam logic [RW-1:0] RATIO_ONE   = 17'h00001;
  localparam logic [RW-1:0] RATIO_128   = 17'h00080;
  localparam logic [RW-1:0] RATIO_TWO   = 17'h00002;
  localparam logic [RW-1:0] RATIO_64    = 17'h00040;
  localparam logic [RW-1:0] RATIO_16K   = 17'h04000;
  localparam logic [RW-1:0] RATIO_64K   = 17'h10000;
  localparam logic [3:0]    CODE_NODIV  = 4'h0;
  localparam logic [3:0]    CODE_FIRST  = 4'h1;
  localparam logic [3:0]    CODE_GP_TOP = 4'h9;
  localparam logic [3:0]    CODE_WK_TOP = 4'h8;
  localparam logic [3:0]    CODE_WK_SML = 4'h9;
  localparam logic [3:0]    CODE_WK_SMT = 4'hd;
  localparam logic [3:0]    CODE_WK_64  = 4'he;

  typedef enum logic [1:0] {
    WGT_IDLE     = 2'b00,
    WGT_INTERVAL = 2'b01,
    WGT_ACTIVE   = 2'b10
  } wgt_wake_state_t;

  // general-purpose prescale decode
  function automatic logic [RW-1:0] wgt_gp_ratio(input logic [3:0] code);
    if (code == CODE_NODIV)
      return RATIO_ONE;
    else if (code <= CODE_GP_TOP)
      return RATIO_128 << (code - CODE_FIRST);
    else
      return RATIO_64K;
  endfunction

  // wake-up prescale decode, small ratios sit above the large ones
  function automatic logic [RW-1:0] wgt_wake_ratio(input logic [3:0] code);
    if (code == CODE_NODIV)
      return RATIO_ONE;
    else if (code <= CODE_WK_TOP)
      return RATIO_128 << (code - CODE_FIRST);
    else if (code <= CODE_WK_SMT)
      return RATIO_TWO << (code - CODE_WK_SML);
    else if (code == CODE_WK_64)
      return RATIO_64;
    else
      return RATIO_16K;
  endfunction

endpackage

// ===== design/wgt_tick.sv
module wgt_tick
  import wgt_pkg::*;
#(
  parameter int CW = 17
)
(
  // clock and reset
  input  wire logic          sys_clk,
  input  wire logic          arst_n,
  // source clock edge and control
  input  wire logic          src_tick,
  input  wire logic          enable,
  input  wire logic          clear,
  input  wire logic [CW-1:0] ratio,
  // divided tick
  output logic               tick
);

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic          last;

  assign last = (cnt_r >= ratio - CW'(1));
  assign tick = enable & src_tick & last;

  // paused prescaler keeps its phase so a resume continues mid-period
  always_comb
  begin
    cnt_nxt = cnt_r;
    if (clear)
      cnt_nxt = '0;
    else if (enable && src_tick)
      cnt_nxt = last ? '0 : cnt_r + CW'(1);
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      cnt_r <= '0;
    else
      cnt_r <= cnt_nxt;
  end

endmodule // wgt_tick

// ===== design/wgt_timers.sv
// How it works
// - low byte forms interval bits seven to zero
// - post-wake time is prescale times duration minus one
// - timer two source bit picks wake or 2MHz
// - timer one source bit picks wake or 2MHz
// - run bit starts, resumes, or pauses keeping count
// - time-out clears the run bit itself
// - prescale code decode, none, 128 doubling, 65536
// - timer two upper nibble, timer one lower
// - timer one period is ratio times period
// - timer two period is ratio times period
// - wake interval is ratio times interval plus one
// - wake clock from external pin or RC
module wgt_timers
  import wgt_pkg::*;
(
  // clock and reset
  input  wire logic          sys_clk,
  input  wire logic          arst_n,
  // register port
  input  wgt_pkg::wgt_bus_req_t bus_req,
  output logic [DW-1:0]      rd_data,
  // clock pins
  input  wire logic          wake_ext_clk_pin,
  input  wire logic          rc_osc_clk,
  input  wire logic          clk_2m,
  // status
  output logic               irq,
  output logic               wake_event,
  output logic               post_wake_active,
  output logic               timer_one_timeout,
  output logic               timer_two_timeout
);

  import wgt_pkg::*;

  localparam int NSRC = 3;
  localparam int SRC_EXT = 0;
  localparam int SRC_RC = 1;
  localparam int SRC_2M = 2;

  // pin synchronisers and edge filters
  logic [NSRC-1:0] s1_r;
  logic [NSRC-1:0] s2_r;
  logic [NSRC-1:0] s3_r;
  logic [NSRC-1:0] filt_r;
  logic [NSRC-1:0] filt_nxt;
  logic [NSRC-1:0] rise;
  logic [NSRC-1:0] pins;

  assign pins = {clk_2m, rc_osc_clk, wake_ext_clk_pin};

  // a level only counts once the second and third stages agree
  always_comb
  begin
    for (int i = 0; i < NSRC; i++)
    begin
      filt_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : filt_r[i];
    end
    rise = filt_nxt & ~filt_r;
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s1_r   <= '0;
      s2_r   <= '0;
      s3_r   <= '0;
      filt_r <= '0;
    end
    else
    begin
      s1_r   <= pins;
      s2_r   <= s1_r;
      s3_r   <= s2_r;
      filt_r <= filt_nxt;
    end
  end

  // register file
  logic [DW-1:0]   sleep_ctrl_r;
  logic [DW-1:0]   sleep_ctrl_nxt;
  logic [DW-1:0]   wake_div_r;
  logic [DW-1:0]   wake_div_nxt;
  logic [DW-1:0]   int_hi_r;
  logic [DW-1:0]   int_hi_nxt;
  logic [DW-1:0]   int_lo_r;
  logic [DW-1:0]   int_lo_nxt;
  logic [DW-1:0]   dur_r;
  logic [DW-1:0]   dur_nxt;
  logic            src1_r;
  logic            src1_nxt;
  logic            src2_r;
  logic            src2_nxt;
  logic            run1_r;
  logic            run1_nxt;
  logic            run2_r;
  logic            run2_nxt;
  logic [DW-1:0]   gt_div_r;
  logic [DW-1:0]   gt_div_nxt;
  logic [DW-1:0]   per1_r;
  logic [DW-1:0]   per1_nxt;
  logic [DW-1:0]   per2_r;
  logic [DW-1:0]   per2_nxt;
  logic [EV_W-1:0] stat_r;
  logic [EV_W-1:0] stat_nxt;
  logic [EV_W-1:0] mask_r;
  logic [EV_W-1:0] mask_nxt;
  logic [DW-1:0]   rd_data_r;
  logic [DW-1:0]   rd_data_nxt;

  // timer state
  logic [DW-1:0]         cnt1_r;
  logic [DW-1:0]         cnt1_nxt;
  logic [DW-1:0]         cnt2_r;
  logic [DW-1:0]         cnt2_nxt;
  logic [15:0]           wcnt_r;
  logic [15:0]           wcnt_nxt;
  wgt_wake_state_t       state_r;
  wgt_wake_state_t       state_nxt;
  logic                  wake_ev_r;
  logic                  post_act_r;
  logic                  to1_r;
  logic                  to2_r;

  logic                  wr_ctrl;
  logic                  wr_gdiv;
  logic                  tick1;
  logic                  tick2;
  logic                  wtick;
  logic                  wsrc;
  logic                  to1;
  logic                  to2;
  logic                  wake_ev;
  logic                  post_done;
  logic                  wclr;
  logic [15:0]           interval;
  logic [DW-1:0]         post_target;
  logic [EV_W-1:0]       ev;
  logic [RW-1:0]         wratio;

  assign wr_ctrl = bus_req.wr && (bus_req.addr == ADDR_GT_CTRL);
  assign wr_gdiv = bus_req.wr && (bus_req.addr == ADDR_GT_DIV);
  assign interval = {int_hi_r, int_lo_r};

  // prescalers
  wgt_tick #(.CW(RW)) u_tick1 (
    .sys_clk  (sys_clk),
    .arst_n   (arst_n),
    .src_tick (src1_r ? rise[SRC_2M] : wsrc),
    .enable   (run1_r),
    .clear    (wr_gdiv),
    .ratio    (wgt_gp_ratio(gt_div_r[DIV_LO_LSB +: 4])),
    .tick     (tick1)
  );

  wgt_tick #(.CW(RW)) u_tick2 (
    .sys_clk  (sys_clk),
    .arst_n   (arst_n),
    .src_tick (src2_r ? rise[SRC_2M] : wsrc),
    .enable   (run2_r),
    .clear    (wr_gdiv),
    .ratio    (wgt_gp_ratio(gt_div_r[DIV_HI_LSB +: 4])),
    .tick     (tick2)
  );

  // post-wake time uses the upper nibble, the interval the lower
  assign wratio = (state_r == WGT_ACTIVE) ? wgt_wake_ratio(wake_div_r[DIV_HI_LSB +: 4])
                                          : wgt_wake_ratio(wake_div_r[DIV_LO_LSB +: 4]);

  wgt_tick #(.CW(RW)) u_wtick (
    .sys_clk  (sys_clk),
    .arst_n   (arst_n),
    .src_tick (wsrc),
    .enable   (state_r != WGT_IDLE),
    .clear    (wclr),
    .ratio    (wratio),
    .tick     (wtick)
  );

  // selected wake clock edge; a net, so every change of select or edge reaches the prescalers
  assign wsrc = sleep_ctrl_r[SC_SRC_BIT] ? rise[SRC_RC] : rise[SRC_EXT];

  // general-purpose counters; period zero expires on the first tick
  assign to1 = tick1 && (({1'b0, cnt1_r} + 9'h001) >= {1'b0, per1_r});
  assign to2 = tick2 && (({1'b0, cnt2_r} + 9'h001) >= {1'b0, per2_r});

  // duration one gives a zero-length window; zero wraps and is not allowed
  assign post_target = dur_r - 8'h01;

  // wake sequencer
  always_comb
  begin
    state_nxt = state_r;
    wcnt_nxt  = wcnt_r;
    wake_ev   = 1'b0;
    post_done = 1'b0;
    case (state_r)
      WGT_IDLE:
      begin
        wcnt_nxt = '0;
        if (sleep_ctrl_r[SC_WAKE_EN_BIT])
          state_nxt = WGT_INTERVAL;
      end
      WGT_INTERVAL:
      begin
        if (wtick)
        begin
          if (wcnt_r >= interval)
          begin
            wake_ev  = 1'b1;
            wcnt_nxt = '0;
            if (sleep_ctrl_r[SC_POST_EN_BIT])
              state_nxt = WGT_ACTIVE;
          end
          else
            wcnt_nxt = wcnt_r + 16'h0001;
        end
      end
      WGT_ACTIVE:
      begin
        if (wcnt_r >= {8'h00, post_target})
        begin
          post_done = 1'b1;
          wcnt_nxt  = '0;
          state_nxt = WGT_INTERVAL;
        end
        else if (wtick)
          wcnt_nxt = wcnt_r + 16'h0001;
      end
      default:
      begin
        state_nxt = WGT_IDLE;
        wcnt_nxt  = '0;
      end
    endcase
    if (!sleep_ctrl_r[SC_WAKE_EN_BIT])
    begin
      state_nxt = WGT_IDLE;
      wcnt_nxt  = '0;
    end
  end

  // restart the prescaler phase at every change of window
  assign wclr = (state_nxt != state_r) || wake_ev;

  always_comb
  begin
    cnt1_nxt = cnt1_r;
    cnt2_nxt = cnt2_r;
    if (to1)
      cnt1_nxt = '0;
    else if (tick1)
      cnt1_nxt = cnt1_r + 8'h01;
    if (to2)
      cnt2_nxt = '0;
    else if (tick2)
      cnt2_nxt = cnt2_r + 8'h01;
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt1_r     <= '0;
      cnt2_r     <= '0;
      wcnt_r     <= '0;
      state_r    <= WGT_IDLE;
      wake_ev_r  <= 1'b0;
      post_act_r <= 1'b0;
      to1_r      <= 1'b0;
      to2_r      <= 1'b0;
    end
    else
    begin
      cnt1_r     <= cnt1_nxt;
      cnt2_r     <= cnt2_nxt;
      wcnt_r     <= wcnt_nxt;
      state_r    <= state_nxt;
      wake_ev_r  <= wake_ev;
      post_act_r <= (state_nxt == WGT_ACTIVE);
      to1_r      <= to1;
      to2_r      <= to2;
    end
  end

  // events, then register writes and reads
  always_comb
  begin
    ev = '0;
    ev[EV_GT1]  = to1;
    ev[EV_GT2]  = to2;
    ev[EV_WAKE] = wake_ev;
    ev[EV_POST] = post_done;
    sleep_ctrl_nxt = sleep_ctrl_r;
    wake_div_nxt   = wake_div_r;
    int_hi_nxt     = int_hi_r;
    int_lo_nxt     = int_lo_r;
    dur_nxt        = dur_r;
    src1_nxt       = src1_r;
    src2_nxt       = src2_r;
    gt_div_nxt     = gt_div_r;
    per1_nxt       = per1_r;
    per2_nxt       = per2_r;
    mask_nxt       = mask_r;
    stat_nxt       = stat_r;
    // a software write of the run bit in the time-out cycle wins: it is a new start
    run1_nxt = to1 ? 1'b0 : run1_r;
    run2_nxt = to2 ? 1'b0 : run2_r;
    if (wr_ctrl)
    begin
      run1_nxt = bus_req.wdata[GT1_RUN_BIT];
      run2_nxt = bus_req.wdata[GT2_RUN_BIT];
      src1_nxt = bus_req.wdata[GT1_SRC_BIT];
      src2_nxt = bus_req.wdata[GT2_SRC_BIT];
    end
    if (bus_req.wr)
    begin
      case (bus_req.addr)
        ADDR_SLEEP_CTRL:  sleep_ctrl_nxt = bus_req.wdata & SLEEP_CTRL_MSK;
        ADDR_WAKE_DIV:    wake_div_nxt = bus_req.wdata;
        ADDR_WAKE_INT_HI: int_hi_nxt = bus_req.wdata;
        ADDR_WAKE_INT_LO: int_lo_nxt = bus_req.wdata;
        ADDR_POST_DUR:    dur_nxt = bus_req.wdata;
        ADDR_GT_DIV:      gt_div_nxt = bus_req.wdata;
        ADDR_GT1_PER:     per1_nxt = bus_req.wdata;
        ADDR_GT2_PER:     per2_nxt = bus_req.wdata;
        ADDR_IRQ_MASK:    mask_nxt = bus_req.wdata[EV_W-1:0];
        ADDR_IRQ_STAT:    stat_nxt = stat_r & ~bus_req.wdata[EV_W-1:0];
        default:          stat_nxt = stat_r;
      endcase
    end
    // set wins over a same-cycle write-one clear
    stat_nxt = stat_nxt | ev;
    rd_data_nxt = '0;
    if (bus_req.rd)
    begin
      case (bus_req.addr)
        ADDR_SLEEP_CTRL:  rd_data_nxt = sleep_ctrl_r;
        ADDR_WAKE_DIV:    rd_data_nxt = wake_div_r;
        ADDR_WAKE_INT_HI: rd_data_nxt = int_hi_r;
        ADDR_WAKE_INT_LO: rd_data_nxt = int_lo_r;
        ADDR_POST_DUR:    rd_data_nxt = dur_r;
        ADDR_GT_CTRL:     rd_data_nxt = {2'b00, src2_r, run2_r, 2'b00, src1_r, run1_r};
        ADDR_GT_DIV:      rd_data_nxt = gt_div_r;
        ADDR_GT1_PER:     rd_data_nxt = per1_r;
        ADDR_GT2_PER:     rd_data_nxt = per2_r;
        ADDR_IRQ_STAT:    rd_data_nxt = {{(DW-EV_W){1'b0}}, stat_r};
        ADDR_IRQ_MASK:    rd_data_nxt = {{(DW-EV_W){1'b0}}, mask_r};
        ADDR_GT1_CNT:     rd_data_nxt = cnt1_r;
        ADDR_GT2_CNT:     rd_data_nxt = cnt2_r;
        default:          rd_data_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sleep_ctrl_r <= SLEEP_CTRL_RST;
      wake_div_r   <= REG_RST;
      int_hi_r     <= REG_RST;
      int_lo_r     <= REG_RST;
      dur_r        <= REG_RST;
      src1_r       <= 1'b0;
      src2_r       <= 1'b0;
      run1_r       <= 1'b0;
      run2_r       <= 1'b0;
      gt_div_r     <= REG_RST;
      per1_r       <= REG_RST;
      per2_r       <= REG_RST;
      stat_r       <= EV_RST;
      mask_r       <= EV_RST;
      rd_data_r    <= REG_RST;
    end
    else
    begin
      sleep_ctrl_r <= sleep_ctrl_nxt;
      wake_div_r   <= wake_div_nxt;
      int_hi_r     <= int_hi_nxt;
      int_lo_r     <= int_lo_nxt;
      dur_r        <= dur_nxt;
      src1_r       <= src1_nxt;
      src2_r       <= src2_nxt;
      run1_r       <= run1_nxt;
      run2_r       <= run2_nxt;
      gt_div_r     <= gt_div_nxt;
      per1_r       <= per1_nxt;
      per2_r       <= per2_nxt;
      stat_r       <= stat_nxt;
      mask_r       <= mask_nxt;
      rd_data_r    <= rd_data_nxt;
    end
  end

  assign rd_data           = rd_data_r;
  assign irq               = |(stat_r & mask_r);
  assign wake_event        = wake_ev_r;
  assign post_wake_active  = post_act_r;
  assign timer_one_timeout = to1_r;
  assign timer_two_timeout = to2_r;

endmodule // wgt_timers

// ===== verification/wgt_chk.sv
module wgt_chk
  import wgt_pkg::*;
(
  // clock and reset
  input wire logic                    sys_clk,
  input wire logic                    arst_n,
  // register port
  input wgt_pkg::wgt_bus_req_t        bus_req,
  input wire logic [wgt_pkg::DW-1:0]  rd_data,
  // clock pins
  input wire logic                    wake_ext_clk_pin,
  input wire logic                    rc_osc_clk,
  input wire logic                    clk_2m,
  // status
  input wire logic                    irq,
  input wire logic                    wake_event,
  input wire logic                    post_wake_active,
  input wire logic                    timer_one_timeout,
  input wire logic                    timer_two_timeout
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  a_rd_idle_zero: assert property (!$past(bus_req.rd) |-> rd_data == 8'h00)
    else $error("read data not zero outside read cycle");
  a_unmapped_zero: assert property (bus_req.rd && bus_req.addr == 8'h00 |=> rd_data == 8'h00)
    else $error("unmapped read not zero");
  a_sleep_bits: assert property (bus_req.rd && bus_req.addr == ADDR_SLEEP_CTRL
    |=> (rd_data & ~SLEEP_CTRL_MSK) == 8'h00)
    else $error("sleep control unused bits set");
  a_mask_off_quiet: assert property (bus_req.wr && bus_req.addr == ADDR_IRQ_MASK && bus_req.wdata == 8'h00
    |=> !irq)
    else $error("irq high with mask cleared");
  a_irq_fall_cause: assert property ($fell(irq) |-> $past(bus_req.wr)
    && ($past(bus_req.addr) == ADDR_IRQ_STAT || $past(bus_req.addr) == ADDR_IRQ_MASK))
    else $error("irq dropped without status or mask write");
  a_irq_rise_cause: assert property ($rose(irq) |-> $past(bus_req.wr) || timer_one_timeout || timer_two_timeout
    || wake_event || $past(wake_event) || ($past(post_wake_active) && !post_wake_active)
    || ($past(post_wake_active, 2) && !$past(post_wake_active)))
    else $error("irq rose without event");
  a_gt1_pulse_one: assert property (timer_one_timeout |=> !timer_one_timeout)
    else $error("timer one pulse too long");
  a_gt2_pulse_one: assert property ($rose(timer_two_timeout) |=> !timer_two_timeout [*8])
    else $error("timer two pulse repeated");
  a_wake_pulse_one: assert property (wake_event |=> !wake_event [*8])
    else $error("wake pulse repeated too soon");
  a_post_after_wake: assert property ($rose(post_wake_active) |-> $past(wake_event) or ##[0:1] wake_event)
    else $error("post window without wake event");
endmodule // wgt_chk

bind wgt_timers wgt_chk u_chk (.sys_clk(sys_clk), .arst_n(arst_n), .bus_req(bus_req), .rd_data(rd_data),
  .wake_ext_clk_pin(wake_ext_clk_pin), .rc_osc_clk(rc_osc_clk), .clk_2m(clk_2m), .irq(irq),
  .wake_event(wake_event), .post_wake_active(post_wake_active), .timer_one_timeout(timer_one_timeout),
  .timer_two_timeout(timer_two_timeout));

// ===== verification/testbench.sv
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_total++; $display("ERROR %0t got %0h want %0h", $time, (a), (b)); end end

module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import wgt_pkg::*;

  logic          sys_clk;
  logic          arst_n;
  wgt_bus_req_t  bus_req;
  logic [7:0]    rd_data;
  logic          irq, wake_event, post_wake_active, timer_one_timeout, timer_two_timeout;
  // source pins: wake ext 4 cycles, rc 8 cycles, 2MHz-ish 12 cycles
  logic          ext_pin = 1'b0;
  logic          rc_clk  = 1'b0;
  logic          clk_2m  = 1'b0;
  logic [2:0]    src_r   = 3'h0;
  logic [3:0]    c12_r   = 4'h0;
  logic [4:0]    obs;
  int            err_total, checks;

  assign obs = {~post_wake_active, post_wake_active, wake_event, timer_two_timeout, timer_one_timeout};

  wgt_timers u_dut (.sys_clk(sys_clk), .arst_n(arst_n), .bus_req(bus_req), .rd_data(rd_data),
    .wake_ext_clk_pin(ext_pin), .rc_osc_clk(rc_clk), .clk_2m(clk_2m), .irq(irq), .wake_event(wake_event),
    .post_wake_active(post_wake_active), .timer_one_timeout(timer_one_timeout),
    .timer_two_timeout(timer_two_timeout));

  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
  begin
    src_r   <= src_r + 3'h1;
    c12_r   <= (c12_r == 4'hb) ? 4'h0 : c12_r + 4'h1;
    ext_pin <= src_r[1];
    rc_clk  <= src_r[2];
    clk_2m  <= (c12_r < 4'h6);
  end

  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge sys_clk);
    bus_req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    bus_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge sys_clk);
    bus_req.rd <= 1'b0;
    #1;
    d = rd_data;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    `CHK(v, e)
  endtask

  // bounded wait; running out ends the run as a failure
  task automatic wait_for(input int idx, input int max, output int n);
    n = 0;
    while (obs[idx] !== 1'b1 && n < max)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (obs[idx] !== 1'b1)
    begin
      err_total++;
      $display("ERROR %0t wait ran out", $time);
      report_and_stop;
    end
  endtask

  task automatic reg_test;
    logic [7:0] adr [15] = '{8'h2d, 8'h2e, 8'h2f, 8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h35,
                            8'h50, 8'h51, 8'h52, 8'h53, 8'h00, 8'h36};
    for (int i = 0; i < 15; i++)
      rd_chk(adr[i], (adr[i] == ADDR_SLEEP_CTRL) ? SLEEP_CTRL_RST : REG_RST);
    for (int i = 1; i < 9; i++)
      if (i != 5)
        wr(adr[i], 8'h5a ^ i[7:0]);
    for (int i = 1; i < 9; i++)
      if (i != 5)
        rd_chk(adr[i], 8'h5a ^ i[7:0]);
    for (int i = 1; i < 9; i++)
      wr(adr[i], 8'h00);
  endtask

  // other nibble holds the slowest code, so a swapped field shows as a hang
  task automatic gp_run(input int t, input logic src, input logic [3:0] code, input logic [7:0] per, input int ratio);
    int sp, n, lo, hi;
    logic [7:0] v;
    sp = src ? 12 : 4;
    lo = (per * ratio - 1) * sp;
    hi = per * ratio * sp + 10;
    wr(t ? ADDR_GT2_PER : ADDR_GT1_PER, per);
    wr(ADDR_GT_DIV, t ? {code, 4'hf} : {4'hf, code});
    wr(ADDR_GT_CTRL, t ? {2'b00, src, 1'b1, 4'h0} : {6'h00, src, 1'b1});
    wait_for(t, hi, n);
    `CHK(n >= lo, 1'b1)
    `CHK(irq, (t == 0))
    rd(ADDR_GT_CTRL, v);
    `CHK(v, t ? {2'b00, src, 5'h00} : {6'h00, src, 1'b0})
    rd(ADDR_IRQ_STAT, v);
    `CHK(v[t], 1'b1)
    wr(ADDR_IRQ_STAT, 8'h0f);
    rd_chk(ADDR_IRQ_STAT, 8'h00);
    `CHK(irq, 1'b0)
  endtask

  task automatic gp_pause;
    logic [7:0] c1, c2;
    int n, hits;
    wr(ADDR_GT1_PER, 8'h28);
    wr(ADDR_GT_DIV, 8'h00);
    wr(ADDR_GT_CTRL, 8'h01);
    repeat (60) @(posedge sys_clk);
    wr(ADDR_GT_CTRL, 8'h00);
    rd(ADDR_GT1_CNT, c1);
    hits = 0;
    repeat (100)
    begin
      @(posedge sys_clk);
      #1;
      hits += timer_one_timeout;
    end
    rd(ADDR_GT1_CNT, c2);
    `CHK(c2, c1)
    `CHK(hits, 0)
    `CHK(c1 > 8'h05 && c1 < 8'h28, 1'b1)
    wr(ADDR_GT_CTRL, 8'h01);
    wait_for(0, (40 - c1) * 4 + 12, n);
    `CHK(n >= (39 - c1) * 4, 1'b1)
    wr(ADDR_IRQ_STAT, 8'h01);
  endtask

  task automatic wake_run(input logic [7:0] sc, input logic [7:0] hb, input int sp);
    int n, e;
    e = ({hb, 8'h02} + 1) * sp;
    wr(ADDR_WAKE_INT_HI, hb);
    wr(ADDR_SLEEP_CTRL, sc);
    wait_for(2, e + 20, n);
    @(posedge sys_clk);
    #1;
    wait_for(2, e + 4, n);
    `CHK(n + 1 >= e - 2 && n + 1 <= e + 2, 1'b1)
    wr(ADDR_SLEEP_CTRL, 8'h00);
  endtask

  // duration 3 gives two ticks of the upper-nibble ratio
  task automatic post_run(input logic [7:0] dv, input int e);
    int n;
    wr(ADDR_WAKE_INT_HI, 8'h00);
    wr(ADDR_WAKE_DIV, dv);
    wr(ADDR_SLEEP_CTRL, 8'h30);
    wait_for(3, 200, n);
    wait_for(4, 200, n);
    `CHK(n >= e - 3 && n <= e + 3, 1'b1)
    wr(ADDR_SLEEP_CTRL, 8'h00);
  endtask

  initial
  begin
    arst_n = 1'b0;
    bus_req = '0;
    err_total = 0;
    checks = 0;
    repeat (20) @(posedge sys_clk);
    arst_n <= 1'b1;
    reg_test;
    wr(ADDR_SLEEP_CTRL, 8'h00);
    wr(ADDR_IRQ_MASK, 8'h01);
    gp_run(0, 1'b1, 4'h0, 8'h04, 1);
    gp_run(0, 1'b0, 4'h1, 8'h01, 128);
    gp_run(1, 1'b1, 4'h0, 8'h04, 1);
    gp_run(1, 1'b0, 4'h2, 8'h01, 256);
    gp_pause;
    wr(ADDR_WAKE_INT_LO, 8'h02);
    wr(ADDR_POST_DUR, 8'h03);
    wake_run(8'h10, 8'h00, 4);
    wake_run(8'h14, 8'h00, 8);
    wake_run(8'h10, 8'h01, 4);
    post_run(8'h00, 8);
    post_run(8'h90, 16);
    wr(ADDR_IRQ_MASK, 8'h0c);
    #1;
    `CHK(irq, 1'b1)
    wr(ADDR_IRQ_MASK, 8'h00);
    #1;
    `CHK(irq, 1'b0)
    wr(ADDR_IRQ_STAT, 8'h0c);
    rd_chk(ADDR_IRQ_STAT, 8'h00);
    report_and_stop;
  end
endmodule // testbench
